/* core/rtc_radio_test_cal_regs.v */
// apb register bank with oscillator overrides, calibration control and pin routing
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "rtc_regs.vh"
module rtc_radio_test_cal_regs (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [7:0] carrierOffset,
  input wire [7:0] bandCalResult,
  input wire [7:0] biasCalResult,
  input wire [7:0] calBand,
  input wire [7:0] calBias,
  output reg [7:0] oscBand,
  output reg [7:0] oscBias,
  output reg [3:0] oscQPhaseLevelRef,
  output reg calOnTransition,
  output reg [2:0] crystalCapTrim,
  output reg [3:0] diagDacGain,
  output reg signalLevelProbeEnable,
  input wire slicerOut,
  input wire cdrOut,
  input wire limitQ,
  input wire limitI,
  input wire limitQFilt,
  input wire limitIFilt,
  input wire pktTxData,
  input wire paRampDone,
  input wire testDacOut,
  input wire irqOut,
  output reg genPinZero,
  output reg genPinOne,
  output reg genPinTwo,
  output reg irqSharedPinThree,
  output reg genPinFive,
  output reg sportEnable,
  output reg [3:0] sportMode
);

// =====================================================
// readback synchroniser for analog-side inputs
reg [7:0] offMeta_q, offSync_q, bandMeta_q, bandSync_q, biasMeta_q, biasSync_q;

// two-stage capture of the carrier offset count
always @(posedge ref_clk) begin
  if (rst) begin
    offMeta_q <= 8'h00;
    offSync_q <= 8'h00;
  end else begin
    offMeta_q <= carrierOffset;
    offSync_q <= offMeta_q;
  end
end

// two-stage capture of the calibrated band result
always @(posedge ref_clk) begin
  if (rst) begin
    bandMeta_q <= 8'h00;
    bandSync_q <= 8'h00;
  end else begin
    bandMeta_q <= bandCalResult;
    bandSync_q <= bandMeta_q;
  end
end

// two-stage capture of the calibrated bias result
always @(posedge ref_clk) begin
  if (rst) begin
    biasMeta_q <= 8'h00;
    biasSync_q <= 8'h00;
  end else begin
    biasMeta_q <= biasCalResult;
    biasSync_q <= biasMeta_q;
  end
end

// =====================================================
// apb slave
reg [7:0] bandOvr_q, biasOvr_q, ovrCtrl_q, calCfg_q, xtalCfg_q;
reg [7:0] probeSel_q, probeMux_q, pinSel_q, dacGain_q;
wire [9:0] regIdx;
wire access;
wire wrEn;
reg hit;
reg [7:0] rdVal;

assign regIdx = paddr[11:2];
assign access = psel & penable;
assign wrEn = access & pwrite;
assign pready = 1'b1; // zero wait states
assign pslverr = access & ~hit;

// read decode and map hit
always @* begin
  hit = 1'b1;
  rdVal = 8'h00;
  case (regIdx)
    `RTC_OFS_CARRIER_OFFSET: rdVal = offSync_q;
    `RTC_OFS_BAND_OVR_VAL: rdVal = bandOvr_q;
    `RTC_OFS_BIAS_OVR_VAL: rdVal = biasOvr_q;
    `RTC_OFS_OVR_CTRL: rdVal = ovrCtrl_q;
    `RTC_OFS_CAL_CFG: rdVal = calCfg_q;
    `RTC_OFS_XTAL_CFG: rdVal = xtalCfg_q;
    `RTC_OFS_BAND_CAL_RES: rdVal = bandSync_q;
    `RTC_OFS_BIAS_CAL_RES: rdVal = biasSync_q;
    `RTC_OFS_PROBE_SEL: rdVal = probeSel_q;
    `RTC_OFS_PROBE_MUX: rdVal = probeMux_q;
    `RTC_OFS_PIN_SEL: rdVal = pinSel_q;
    `RTC_OFS_DAC_GAIN: rdVal = dacGain_q;
    default: hit = 1'b0;
  endcase
  if (paddr[1:0] != 2'h0 || paddr[31:12] != 20'h00000) begin
    hit = 1'b0;
    rdVal = 8'h00;
  end
end

// registered read data
always @(posedge ref_clk) begin
  if (rst) begin
    prdata <= 32'h00000000;
  end else if (psel & ~penable & ~pwrite) begin
    // loaded in setup so it stands through the zero-wait access cycle
    prdata <= {24'h000000, rdVal};
  end
end

// =====================================================
// per-register write strobes
wire wrBandOvr;
wire wrBiasOvr;
wire wrOvrCtrl;
wire wrCalCfg;
wire wrXtalCfg;
wire wrProbeSel;
wire wrProbeMux;
wire wrPinSel;
wire wrDacGain;

// a strobe needs a mapped, aligned write in the access phase
assign wrBandOvr = wrEn & hit & (regIdx == `RTC_OFS_BAND_OVR_VAL);
assign wrBiasOvr = wrEn & hit & (regIdx == `RTC_OFS_BIAS_OVR_VAL);
assign wrOvrCtrl = wrEn & hit & (regIdx == `RTC_OFS_OVR_CTRL);
assign wrCalCfg = wrEn & hit & (regIdx == `RTC_OFS_CAL_CFG);
assign wrXtalCfg = wrEn & hit & (regIdx == `RTC_OFS_XTAL_CFG);
assign wrProbeSel = wrEn & hit & (regIdx == `RTC_OFS_PROBE_SEL);
assign wrProbeMux = wrEn & hit & (regIdx == `RTC_OFS_PROBE_MUX);
assign wrPinSel = wrEn & hit & (regIdx == `RTC_OFS_PIN_SEL);
assign wrDacGain = wrEn & hit & (regIdx == `RTC_OFS_DAC_GAIN);

// =====================================================
// configuration registers; reserved bits stored and read back as written

// band override value
always @(posedge ref_clk) begin
  if (rst) begin
    bandOvr_q <= 8'h00;
  end else if (wrBandOvr) begin
    bandOvr_q <= pwdata[7:0];
  end
end

// bias override value
always @(posedge ref_clk) begin
  if (rst) begin
    biasOvr_q <= 8'h00;
  end else if (wrBiasOvr) begin
    biasOvr_q <= pwdata[7:0];
  end
end

// override enables and q phase reference
always @(posedge ref_clk) begin
  if (rst) begin
    ovrCtrl_q <= 8'h00;
  end else if (wrOvrCtrl) begin
    ovrCtrl_q <= pwdata[7:0];
  end
end

// calibration configuration, calibration on by default
always @(posedge ref_clk) begin
  if (rst) begin
    calCfg_q <= {4'h0, `RTC_RST_CAL_CFG};
  end else if (wrCalCfg) begin
    calCfg_q <= pwdata[7:0];
  end
end

// crystal tuning configuration
always @(posedge ref_clk) begin
  if (rst) begin
    xtalCfg_q <= 8'h00;
  end else if (wrXtalCfg) begin
    xtalCfg_q <= pwdata[7:0];
  end
end

// analog probe selection
always @(posedge ref_clk) begin
  if (rst) begin
    probeSel_q <= 8'h00;
  end else if (wrProbeSel) begin
    probeSel_q <= pwdata[7:0];
  end
end

// signal level probe multiplexer
always @(posedge ref_clk) begin
  if (rst) begin
    probeMux_q <= 8'h00;
  end else if (wrProbeMux) begin
    probeMux_q <= pwdata[7:0];
  end
end

// pin function selector
always @(posedge ref_clk) begin
  if (rst) begin
    pinSel_q <= 8'h00;
  end else if (wrPinSel) begin
    pinSel_q <= pwdata[7:0];
  end
end

// diagnostic dac gain
always @(posedge ref_clk) begin
  if (rst) begin
    dacGain_q <= {4'h0, `RTC_RST_DAC_GAIN};
  end else if (wrDacGain) begin
    dacGain_q <= pwdata[7:0];
  end
end

// =====================================================
// oscillator controls (registered)

// band: programmed value while its enable is set
always @(posedge ref_clk) begin
  if (rst) begin
    oscBand <= 8'h00;
  end else begin
    oscBand <= ovrCtrl_q[`RTC_BIT_BAND_OVR_EN] ? bandOvr_q : calBand;
  end
end

// bias: programmed value while its enable is set
always @(posedge ref_clk) begin
  if (rst) begin
    oscBias <= 8'h00;
  end else begin
    oscBias <= ovrCtrl_q[`RTC_BIT_BIAS_OVR_EN] ? biasOvr_q : calBias;
  end
end

// q phase amplitude reference field
always @(posedge ref_clk) begin
  if (rst) begin
    oscQPhaseLevelRef <= 4'h0;
  end else begin
    oscQPhaseLevelRef <= ovrCtrl_q[`RTC_Q_REF_HI:`RTC_Q_REF_LO];
  end
end

// bypass only on 0xF, any other value keeps calibration running
always @(posedge ref_clk) begin
  if (rst) begin
    calOnTransition <= 1'b1;
  end else begin
    calOnTransition <= (calCfg_q[3:0] != `RTC_CAL_BYPASS);
  end
end

// =====================================================
// crystal, dac and probe controls (registered)

// crystal capacitor trim field
always @(posedge ref_clk) begin
  if (rst) begin
    crystalCapTrim <= 3'h0;
  end else begin
    crystalCapTrim <= xtalCfg_q[`RTC_CAP_HI:`RTC_CAP_LO];
  end
end

// diagnostic dac gain field
always @(posedge ref_clk) begin
  if (rst) begin
    diagDacGain <= `RTC_RST_DAC_GAIN;
  end else begin
    diagDacGain <= dacGain_q[3:0];
  end
end

// signal level probe needs both selections at once
always @(posedge ref_clk) begin
  if (rst) begin
    signalLevelProbeEnable <= 1'b0;
  end else begin
    signalLevelProbeEnable <= (probeSel_q == `RTC_PROBE_RSSI) &&
      (probeMux_q[1:0] == `RTC_MUX_RSSI);
  end
end

// =====================================================
// pin function routing, outputs registered

// selector inside the serial port mode range
wire inSportRange;
assign inSportRange = (pinSel_q >= `RTC_PIN_SPORT_LO) && (pinSel_q <= `RTC_PIN_SPORT_HI);

// one selector value drives all routed pins
always @(posedge ref_clk) begin
  if (rst) begin
    genPinZero <= 1'b0;
    genPinOne <= 1'b0;
    genPinTwo <= 1'b0;
    irqSharedPinThree <= 1'b0;
    genPinFive <= 1'b0;
    sportEnable <= 1'b0;
    sportMode <= 4'h0;
  end else begin
    // default functions: pins idle low, irq on pin three, recovered data on pin five
    genPinZero <= 1'b0;
    genPinOne <= 1'b0;
    genPinTwo <= 1'b0;
    irqSharedPinThree <= irqOut;
    genPinFive <= cdrOut;
    sportEnable <= 1'b0;
    sportMode <= 4'h0;
    case (pinSel_q)
      `RTC_PIN_SLICER: genPinFive <= slicerOut;
      `RTC_PIN_LIMIT: begin
        genPinZero <= limitQ;
        genPinOne <= limitI;
      end
      `RTC_PIN_LIMIT_FILT: begin
        genPinZero <= limitQFilt;
        genPinOne <= limitIFilt;
        genPinTwo <= limitQ;
        irqSharedPinThree <= limitI;
      end
      `RTC_PIN_PKT_TX: genPinZero <= pktTxData;
      `RTC_PIN_PA_RAMP: genPinZero <= paRampDone;
      `RTC_PIN_TEST_DAC: genPinZero <= testDacOut;
      default: begin
        if (inSportRange) begin
          sportEnable <= 1'b1;
          sportMode <= pinSel_q[3:0];
        end
      end
    endcase
  end
end

endmodule

/* core/rtc_regs.vh */
// register offsets, field positions and reset values of the radio test/cal register bank
`ifndef RTC_REGS_VH
`define RTC_REGS_VH
`define RTC_OFS_CARRIER_OFFSET 10'h372
`define RTC_OFS_BAND_OVR_VAL 10'h3CB
`define RTC_OFS_BIAS_OVR_VAL 10'h3CC
`define RTC_OFS_OVR_CTRL 10'h3CD
`define RTC_OFS_CAL_CFG 10'h3D0
`define RTC_OFS_XTAL_CFG 10'h3D2
`define RTC_OFS_BAND_CAL_RES 10'h3DA
`define RTC_OFS_BIAS_CAL_RES 10'h3DB
`define RTC_OFS_PROBE_SEL 10'h3F8
`define RTC_OFS_PROBE_MUX 10'h3F9
`define RTC_OFS_PIN_SEL 10'h3FA
`define RTC_OFS_DAC_GAIN 10'h3FD
`define RTC_BIT_BAND_OVR_EN 0
`define RTC_BIT_BIAS_OVR_EN 1
`define RTC_Q_REF_HI 5
`define RTC_Q_REF_LO 2
`define RTC_CAP_HI 5
`define RTC_CAP_LO 3
`define RTC_RST_CAL_CFG 4'h1
`define RTC_RST_DAC_GAIN 4'h4
`define RTC_CAL_BYPASS 4'hF
`define RTC_CAL_ENABLE 4'h1
`define RTC_PROBE_RSSI 8'h64
`define RTC_MUX_RSSI 2'h3
`define RTC_PIN_DEFAULT 8'h00
`define RTC_PIN_SLICER 8'h21
`define RTC_PIN_LIMIT 8'h40
`define RTC_PIN_LIMIT_FILT 8'h41
`define RTC_PIN_PKT_TX 8'h50
`define RTC_PIN_PA_RAMP 8'h53
`define RTC_PIN_SPORT_LO 8'hA0
`define RTC_PIN_SPORT_HI 8'hA8
`define RTC_PIN_TEST_DAC 8'hC9
`endif

/* sim/rtc_radio_test_cal_regs_chk.sv */
// port assertions for the radio test and calibration register bank
`timescale 1ns/1ns
`include "rtc_regs.vh"
module rtc_radio_test_cal_regs_chk (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [3:0] oscQPhaseLevelRef,
  input wire calOnTransition,
  input wire [2:0] crystalCapTrim,
  input wire [3:0] diagDacGain,
  input wire sportEnable,
  input wire [3:0] sportMode
);
  // ==========================================
  // access decode
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // ==========================================
  // assertions
  a_zero_wait: assert property (acc |-> pready) else $error("pready low in access");
  a_bad_addr: assert property (acc && (paddr[1:0] != 0 || paddr[31:12] != 0) |-> pslverr)
    else $error("unmapped access not flagged");
  a_qref_write: assert property (wr && paddr == 4*`RTC_OFS_OVR_CTRL |->
    ##2 oscQPhaseLevelRef == $past(pwdata[5:2], 2)) else $error("q reference wrong");
  a_cap_write: assert property (wr && paddr == 4*`RTC_OFS_XTAL_CFG |->
    ##2 crystalCapTrim == $past(pwdata[5:3], 2)) else $error("cap trim wrong");
  a_gain_write: assert property (wr && paddr == 4*`RTC_OFS_DAC_GAIN |->
    ##2 diagDacGain == $past(pwdata[3:0], 2)) else $error("dac gain wrong");
  a_cal_bypass: assert property (wr && paddr == 4*`RTC_OFS_CAL_CFG && pwdata[3:0] == 4'hF |->
    ##2 !calOnTransition) else $error("calibration not bypassed");
  a_cal_enable: assert property (wr && paddr == 4*`RTC_OFS_CAL_CFG && pwdata[3:0] == 4'h1 |->
    ##2 calOnTransition) else $error("calibration not enabled");
  a_sport_mode: assert property (wr && paddr == 4*`RTC_OFS_PIN_SEL && pwdata[7:4] == 4'hA
    && pwdata[3:0] <= 4'h8 |-> ##2 sportEnable && sportMode == $past(pwdata[3:0], 2))
    else $error("serial port mode wrong");
  a_reset_vals: assert property ($fell(rst) |-> calOnTransition && diagDacGain == 4'h4
    && oscQPhaseLevelRef == 4'h0) else $error("reset values wrong");
  // main scenarios
  c_err: cover property (acc && pslverr);
  c_limit: cover property (wr && paddr == 4*`RTC_OFS_PIN_SEL && pwdata[7:0] == 8'h41);
  c_bypass: cover property (wr && paddr == 4*`RTC_OFS_CAL_CFG && pwdata[3:0] == 4'hF);
endmodule
bind rtc_radio_test_cal_regs rtc_radio_test_cal_regs_chk chk (.*);

/* sim/rtc_radio_test_cal_regs_tb.sv */
// self-checking bench for the radio test and calibration register bank
`timescale 1ns/1ns
`include "rtc_regs.vh"
module rtc_radio_test_cal_regs_tb;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
  logic [7:0] carrierOffset = 0, bandCalResult = 0, biasCalResult = 0, calBand = 0, calBias = 0;
  logic slicerOut = 0, cdrOut = 0, limitQ = 0, limitI = 0, limitQFilt = 0, limitIFilt = 0;
  logic pktTxData = 0, paRampDone = 0, testDacOut = 0, irqOut = 0;
  logic [7:0] oscBand, oscBias, d, a, b, s;
  logic [3:0] oscQPhaseLevelRef, diagDacGain, sportMode;
  logic [2:0] crystalCapTrim;
  logic calOnTransition, signalLevelProbeEnable, sportEnable;
  logic genPinZero, genPinOne, genPinTwo, irqSharedPinThree, genPinFive;
  int miscompares = 0, checks = 0;
  logic [9:0] ofs [12] = '{`RTC_OFS_CARRIER_OFFSET, `RTC_OFS_BAND_OVR_VAL, `RTC_OFS_BIAS_OVR_VAL,
    `RTC_OFS_OVR_CTRL, `RTC_OFS_CAL_CFG, `RTC_OFS_XTAL_CFG, `RTC_OFS_BAND_CAL_RES,
    `RTC_OFS_BIAS_CAL_RES, `RTC_OFS_PROBE_SEL, `RTC_OFS_PROBE_MUX, `RTC_OFS_PIN_SEL,
    `RTC_OFS_DAC_GAIN};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h04};
  logic [7:0] sel [9] = '{8'h00, 8'h21, 8'h40, 8'h41, 8'h50, 8'h53, 8'hC9, 8'hA9, 8'hFF};
  rtc_radio_test_cal_regs dut (.*);
  // ==========================================
  // clock and tasks
  always #5 ref_clk = ~ref_clk;
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task xfer(input logic w, input logic [31:0] adr, input logic [7:0] wd);
    psel <= 1; pwrite <= w; paddr <= adr; pwdata <= {24'h0, wd};
    @(posedge ref_clk) penable <= 1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge ref_clk);
  endtask
  // expected pins {zero, one, two, three, five} for a selector value
  function automatic logic [4:0] pinExp(input logic [7:0] v);
    pinExp = {3'b000, irqOut, cdrOut};
    case (v)
      8'h21: pinExp[0] = slicerOut;
      8'h40: pinExp[4:3] = {limitQ, limitI};
      8'h41: pinExp[4:1] = {limitQFilt, limitIFilt, limitQ, limitI};
      8'h50: pinExp[4] = pktTxData;
      8'h53: pinExp[4] = paRampDone;
      8'hC9: pinExp[4] = testDacOut;
      default: ;
    endcase
  endfunction
  task pinCase(input logic [7:0] v);
    xfer(1, 4*`RTC_OFS_PIN_SEL, v);
    repeat (4) begin
      {slicerOut, cdrOut, limitQ, limitI, limitQFilt, limitIFilt, pktTxData, paRampDone,
        testDacOut, irqOut} <= 10'($urandom);
      repeat (2) @(posedge ref_clk);
      chk("pins", {genPinZero, genPinOne, genPinTwo, irqSharedPinThree, genPinFive},
        pinExp(v));
      chk("sport", sportEnable, v >= 8'hA0 && v <= 8'hA8);
      chk("sportmode", sportMode, (v >= 8'hA0 && v <= 8'hA8) ? v[3:0] : 4'h0);
    end
  endtask
  task final_report;
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================
  // watchdog and main sequence
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
  initial begin
    void'($urandom(53));
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    for (int i = 0; i < 12; i++) begin
      xfer(0, 4*ofs[i], 8'h00);
      chk("reset", rd, rv[i]);
    end
    repeat (3) for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      xfer(1, 4*ofs[i], d);
      xfer(0, 4*ofs[i], 8'h00);
      chk("readback", rd, (i == 0 || i == 6 || i == 7) ? 8'h00 : d);
    end
    {carrierOffset, bandCalResult, biasCalResult} <= {8'h9C, 16'($urandom)};
    repeat (3) @(posedge ref_clk);
    xfer(0, 4*`RTC_OFS_CARRIER_OFFSET, 8'h00);
    chk("offset", rd, 8'h9C);
    xfer(0, 4*`RTC_OFS_BAND_CAL_RES, 8'h00);
    chk("bandres", rd, bandCalResult);
    xfer(0, 4*`RTC_OFS_BIAS_CAL_RES, 8'h00);
    chk("biasres", rd, biasCalResult);
    xfer(1, 4*10'h373, 8'h55);
    chk("unmapped wr err", err, 1'b1);
    xfer(0, 4*10'h373, 8'h00);
    chk("unmapped rd err", err, 1'b1);
    chk("unmapped rd data", rd, 32'h00000000);
    xfer(1, 4*`RTC_OFS_CAL_CFG + 2, 8'h0F);
    chk("misaligned err", err, 1'b1);
    xfer(1, 4*`RTC_OFS_CAL_CFG, 8'h0F);
    @(posedge ref_clk);
    chk("cal bypass", calOnTransition, 1'b0);
    xfer(1, 4*`RTC_OFS_CAL_CFG, 8'h01);
    @(posedge ref_clk);
    chk("cal enable", calOnTransition, 1'b1);
    a = 8'($urandom);
    b = 8'($urandom);
    calBand <= 8'($urandom);
    calBias <= 8'($urandom);
    xfer(1, 4*`RTC_OFS_BAND_OVR_VAL, a);
    xfer(1, 4*`RTC_OFS_BIAS_OVR_VAL, b);
    for (int c = 3; c >= 0; c--) begin
      xfer(1, 4*`RTC_OFS_OVR_CTRL, 8'(c));
      repeat (2) @(posedge ref_clk);
      chk("band", oscBand, c[0] ? a : calBand);
      chk("bias", oscBias, c[1] ? b : calBias);
    end
    for (int p = 0; p < 4; p++) begin
      xfer(1, 4*`RTC_OFS_PROBE_SEL, p[0] ? 8'h64 : 8'h65);
      xfer(1, 4*`RTC_OFS_PROBE_MUX, p[1] ? 8'h03 : 8'h02);
      repeat (2) @(posedge ref_clk);
      chk("probe", signalLevelProbeEnable, p == 3);
    end
    foreach (sel[k]) pinCase(sel[k]);
    for (int j = 0; j < 9; j++) pinCase(8'hA0 + 8'(j));
    final_report;
  end
endmodule
